// >>> rtl/adrc_pin_mux.sv
/*
 * One general pin: selects its output from a five-bit function code.
 * Assumes every input is synchronous to core_clk.
 */
module adrc_pin_mux #(
    parameter logic DEFAULT_LEVEL = 1'b0
) (
    input  wire logic                        core_clk,     // System clock.
    input  wire logic                        rst,          // Synchronous reset.
    input  wire logic [adrc_pkg::FUNC_W-1:0] func_code,    // Pin function code.
    input  wire logic                        ant_one_sel,  // Antenna one line.
    input  wire logic                        ant_two_sel,  // Antenna two line.
    input  wire logic                        cca_level,    // Clear-channel flag.
    output logic                             pin_out_r     // Registered pin level.
);
    import adrc_pkg::*;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            pin_out_r <= DEFAULT_LEVEL;
        end else begin
            case (func_code)
                FUNC_DEFAULT:       pin_out_r <= DEFAULT_LEVEL;
                FUNC_ANT_ONE:       pin_out_r <= ant_one_sel;
                FUNC_ANT_TWO:       pin_out_r <= ant_two_sel;
                FUNC_CLEAR_CHANNEL: pin_out_r <= cca_level;
                default:            pin_out_r <= 1'b0;
            endcase
        end
    end

endmodule

// >>> rtl/adrc_pkg.sv
/*
 * Shared constants for the antenna diversity, signal strength and
 * clear-channel block: register offsets, field positions, reset values,
 * pin function codes, dwell counts and the diversity state encoding.
 * Assumes an 8-bit register bus with byte offsets as listed here.
 */
package adrc_pkg;

    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;

    // Register offsets.
    localparam logic [7:0] OFS_OPER_CTRL_TWO  = 8'h08;
    localparam logic [7:0] OFS_PIN_CFG_ZERO   = 8'h0B;
    localparam logic [7:0] OFS_PIN_CFG_ONE    = 8'h0C;
    localparam logic [7:0] OFS_PIN_CFG_TWO    = 8'h0D;
    localparam logic [7:0] OFS_STRENGTH       = 8'h26;
    localparam logic [7:0] OFS_CC_THRESHOLD   = 8'h27;
    localparam logic [7:0] OFS_DIV_STATUS     = 8'h40;

    // Reset values.
    localparam logic [7:0] RST_OPER_CTRL_TWO  = 8'h00;
    localparam logic [7:0] RST_PIN_CFG        = 8'h00;
    localparam logic [7:0] RST_CC_THRESHOLD   = 8'h00;

    // Field positions.
    localparam int unsigned MODE_LSB          = 5;
    localparam int unsigned MODE_W            = 3;
    localparam int unsigned FUNC_W            = 5;
    localparam int unsigned ST_CCA_BIT        = 0;
    localparam int unsigned ST_CHOSEN_BIT     = 1;
    localparam int unsigned ST_STATE_LSB      = 2;

    // Pin function codes.
    localparam logic [4:0] FUNC_DEFAULT       = 5'h00;
    localparam logic [4:0] FUNC_CLEAR_CHANNEL = 5'h0E;
    localparam logic [4:0] FUNC_ANT_ONE       = 5'h17;
    localparam logic [4:0] FUNC_ANT_TWO       = 5'h18;

    // Dwell per antenna, counted in strength update ticks (one per 4 bit periods).
    localparam int unsigned DWELL_ASYNC_TICKS  = 2;
    localparam int unsigned DWELL_BEACON_TICKS = 1;
    localparam int unsigned DWELL_W            = 4;

    typedef enum logic [2:0] {
        ADRC_IDLE   = 3'b000,
        ADRC_SEEK   = 3'b001,
        ADRC_MEAS_A = 3'b011,
        ADRC_MEAS_B = 3'b010,
        ADRC_HOLD   = 3'b110
    } adrc_state_t;

endpackage

// >>> rtl/adrc_strength_sampler.sv
/*
 * Holds the latest signal strength estimate from the demodulator.
 * Assumes the strength update tick is a one-cycle enable pulse.
 */
module adrc_strength_sampler #(
    parameter int unsigned WIDTH = 8
) (
    input  wire logic             core_clk,     // System clock.
    input  wire logic             rst,          // Synchronous reset, active high.
    input  wire logic             update_tick,  // Strength update window pulse.
    input  wire logic [WIDTH-1:0] strength_in,  // Raw strength from demodulator.
    output logic      [WIDTH-1:0] strength_r    // Held strength value.
);
    import adrc_pkg::*;

    // The value only moves on the update tick; host reads never touch it.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            strength_r <= '0;
        end else if (update_tick) begin
            strength_r <= strength_in;
        end
    end

endmodule

// >>> rtl/adrc_top.sv
/*
 * Antenna diversity control, signal strength register and clear-channel
 * assessment, with a simple register port and three general pins.
 * Assumes radio state levels, the strength tick, preamble and packet end
 * pulses come from the modem, all synchronous to core_clk.
 */

module adrc_top (
    input  wire logic                        core_clk,       // System clock, 40 MHz.
    input  wire logic                        rst,            // Synchronous reset.
    input  wire logic [adrc_pkg::ADDR_W-1:0] reg_addr,       // Register address.
    input  wire logic [adrc_pkg::DATA_W-1:0] reg_wdata,      // Register write data.
    input  wire logic                        reg_wr,         // Write strobe.
    input  wire logic                        reg_rd,         // Read strobe.
    output logic      [adrc_pkg::DATA_W-1:0] reg_rdata,      // Read data, next cycle.
    input  wire logic                        rx_active,      // Radio in receive state.
    input  wire logic                        tx_active,      // Radio in transmit state.
    input  wire logic                        strength_tick,  // Once every 4 bit periods.
    input  wire logic [7:0]                  strength_in,    // Strength from demodulator.
    input  wire logic                        preamble_seen,  // Preamble detected pulse.
    input  wire logic                        packet_end,     // End of packet pulse.
    output logic                             ant_one_sel,    // Switch line one.
    output logic                             ant_two_sel,    // Switch line two.
    output logic                             cca_status,     // Above threshold flag.
    output logic      [2:0]                  pin_out         // General pin levels.
);
    import adrc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Registers and state.

    logic [7:0]        oper_ctrl_two_r;
    logic [7:0]        pin_cfg_r [3];
    logic [7:0]        cc_threshold_r;
    logic [7:0]        strength_r;
    logic [2:0]        mode;
    logic              rx_prev_r;
    logic              rx_entry;
    logic              radio_on;
    adrc_state_t       state_r;
    adrc_state_t       state_nxt;
    logic [DWELL_W-1:0] dwell_r;
    logic [DWELL_W-1:0] dwell_len;
    logic              dwell_done;
    logic [7:0]        str_a_r;
    logic              meas_ant_two_r;
    logic              chosen_two_r;
    logic              cca_r;
    logic              ant_one_nxt;
    logic              ant_two_nxt;

    assign mode      = oper_ctrl_two_r[MODE_LSB +: MODE_W];
    assign rx_entry  = rx_active & ~rx_prev_r;
    assign radio_on  = rx_active | tx_active;
    assign dwell_len = mode[1] ? DWELL_W'(DWELL_BEACON_TICKS)
                               : DWELL_W'(DWELL_ASYNC_TICKS);
    assign dwell_done = strength_tick && (dwell_r == dwell_len - DWELL_W'(1));

    // Greater-than test used by both the antenna choice and the threshold.
    function automatic logic stronger(input logic [7:0] a, input logic [7:0] b);
        return a > b;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Strength sampler.

    adrc_strength_sampler #(
        .WIDTH (8)
    ) u_sampler (
        .core_clk    (core_clk),
        .rst         (rst),
        .update_tick (strength_tick),
        .strength_in (strength_in),
        .strength_r  (strength_r)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Register writes.

    always_ff @(posedge core_clk) begin
        if (rst) begin
            oper_ctrl_two_r <= RST_OPER_CTRL_TWO;
            cc_threshold_r  <= RST_CC_THRESHOLD;
            for (int i = 0; i < 3; i++) begin
                pin_cfg_r[i] <= RST_PIN_CFG;
            end
        end else if (reg_wr) begin
            case (reg_addr)
                OFS_OPER_CTRL_TWO: oper_ctrl_two_r <= reg_wdata;
                OFS_CC_THRESHOLD:  cc_threshold_r  <= reg_wdata;
                OFS_PIN_CFG_ZERO:  pin_cfg_r[0]    <= reg_wdata;
                OFS_PIN_CFG_ONE:   pin_cfg_r[1]    <= reg_wdata;
                OFS_PIN_CFG_TWO:   pin_cfg_r[2]    <= reg_wdata;
                default:           ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register reads; a read has no effect beyond returning data.

    always_ff @(posedge core_clk) begin
        if (rst) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            case (reg_addr)
                OFS_OPER_CTRL_TWO: reg_rdata <= oper_ctrl_two_r;
                OFS_CC_THRESHOLD:  reg_rdata <= cc_threshold_r;
                OFS_STRENGTH:      reg_rdata <= strength_r;
                OFS_PIN_CFG_ZERO:  reg_rdata <= pin_cfg_r[0];
                OFS_PIN_CFG_ONE:   reg_rdata <= pin_cfg_r[1];
                OFS_PIN_CFG_TWO:   reg_rdata <= pin_cfg_r[2];
                OFS_DIV_STATUS:    reg_rdata <= {3'h0, state_r, chosen_two_r, cca_r};
                default:           reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Diversity sequencer.

    always_ff @(posedge core_clk) begin
        if (rst) begin
            rx_prev_r <= 1'b0;
        end else begin
            rx_prev_r <= rx_active;
        end
    end

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ADRC_IDLE: begin
                if (rx_entry && mode[2]) begin
                    state_nxt = mode[1] ? ADRC_MEAS_A : ADRC_SEEK;
                end
            end
            ADRC_SEEK: begin
                if (preamble_seen) begin
                    state_nxt = ADRC_MEAS_A;
                end
            end
            ADRC_MEAS_A: begin
                if (dwell_done) begin
                    state_nxt = ADRC_MEAS_B;
                end
            end
            ADRC_MEAS_B: begin
                if (dwell_done) begin
                    state_nxt = ADRC_HOLD;
                end
            end
            ADRC_HOLD: begin
                if (packet_end) begin
                    state_nxt = ADRC_IDLE;
                end
            end
            default: state_nxt = ADRC_IDLE;
        endcase
        if (!rx_active || !mode[2]) begin
            state_nxt = ADRC_IDLE;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_r <= ADRC_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Dwell counter restarts on every state change and counts strength ticks.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            dwell_r <= '0;
        end else if (state_nxt != state_r) begin
            dwell_r <= '0;
        end else if (strength_tick) begin
            dwell_r <= dwell_r + DWELL_W'(1);
        end
    end

    // While seeking, the antennas swap after the first dwell, then every 16 ticks as the count wraps, so either can catch arrival.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            meas_ant_two_r <= 1'b0;
        end else begin
            case (state_nxt)
                ADRC_SEEK:   meas_ant_two_r <= (state_r == ADRC_SEEK && dwell_done)
                                               ? ~meas_ant_two_r : meas_ant_two_r;
                ADRC_MEAS_A: meas_ant_two_r <= 1'b0;
                ADRC_MEAS_B: meas_ant_two_r <= 1'b1;
                default:     meas_ant_two_r <= meas_ant_two_r;
            endcase
        end
    end

    // Strength of antenna one captured at the end of its dwell. The sampler copy
    // only takes this tick's value at the same edge, so the fresh input is used.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            str_a_r <= '0;
        end else if (state_r == ADRC_MEAS_A && dwell_done) begin
            str_a_r <= strength_in;
        end
    end

    // The choice survives packet end so the next transmit uses it.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            chosen_two_r <= 1'b0;
        end else if (state_r == ADRC_MEAS_B && dwell_done) begin
            chosen_two_r <= stronger(strength_in, str_a_r);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Clear-channel decision, made once per preamble evaluation.

    always_ff @(posedge core_clk) begin
        if (rst) begin
            cca_r <= 1'b0;
        end else if (state_r == ADRC_MEAS_B && dwell_done) begin
            cca_r <= stronger(stronger(strength_in, str_a_r) ? strength_in : str_a_r,
                              cc_threshold_r);
        end else if (!mode[2] && rx_active && preamble_seen) begin
            cca_r <= stronger(strength_r, cc_threshold_r);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Switch line outputs.

    always_comb begin
        if (!radio_on) begin
            ant_one_nxt = (mode[1] & ~mode[2]) | (mode[2] & mode[0]);
            ant_two_nxt = ant_one_nxt;
        end else if (!mode[2]) begin
            ant_one_nxt = mode[0];
            ant_two_nxt = ~mode[0];
        end else if (rx_active && state_r != ADRC_HOLD && state_r != ADRC_IDLE) begin
            ant_one_nxt = ~meas_ant_two_r;
            ant_two_nxt = meas_ant_two_r;
        end else begin
            ant_one_nxt = ~chosen_two_r;
            ant_two_nxt = chosen_two_r;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            ant_one_sel <= 1'b0;
            ant_two_sel <= 1'b0;
            cca_status  <= 1'b0;
        end else begin
            ant_one_sel <= ant_one_nxt;
            ant_two_sel <= ant_two_nxt;
            cca_status  <= cca_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // General pins; only the default level differs, high on pin one and low on pins zero and two.

    adrc_pin_mux #(
        .DEFAULT_LEVEL (1'b0)
    ) u_pin0 (
        .core_clk    (core_clk),
        .rst         (rst),
        .func_code   (pin_cfg_r[0][FUNC_W-1:0]),
        .ant_one_sel (ant_one_nxt),
        .ant_two_sel (ant_two_nxt),
        .cca_level   (cca_r),
        .pin_out_r   (pin_out[0])
    );

    adrc_pin_mux #(
        .DEFAULT_LEVEL (1'b1)
    ) u_pin1 (
        .core_clk    (core_clk),
        .rst         (rst),
        .func_code   (pin_cfg_r[1][FUNC_W-1:0]),
        .ant_one_sel (ant_one_nxt),
        .ant_two_sel (ant_two_nxt),
        .cca_level   (cca_r),
        .pin_out_r   (pin_out[1])
    );

    adrc_pin_mux #(
        .DEFAULT_LEVEL (1'b0)
    ) u_pin2 (
        .core_clk    (core_clk),
        .rst         (rst),
        .func_code   (pin_cfg_r[2][FUNC_W-1:0]),
        .ant_one_sel (ant_one_nxt),
        .ant_two_sel (ant_two_nxt),
        .cca_level   (cca_r),
        .pin_out_r   (pin_out[2])
    );

endmodule

// >>> sim/adrc_monitor.sv
/*
 * Checker for adrc_top: shadows the writable registers and judges read
 * data, switch lines and pins against them.
 * Assumes it is bound to adrc_top and sees only that module's ports.
 */
module adrc_monitor (
    input wire logic                        core_clk,       // Clock.
    input wire logic                        rst,            // Reset.
    input wire logic [adrc_pkg::ADDR_W-1:0] reg_addr,       // Address.
    input wire logic [adrc_pkg::DATA_W-1:0] reg_wdata,      // Write data.
    input wire logic                        reg_wr,         // Write strobe.
    input wire logic                        reg_rd,         // Read strobe.
    input wire logic [adrc_pkg::DATA_W-1:0] reg_rdata,      // Read data.
    input wire logic                        rx_active,      // Receive.
    input wire logic                        tx_active,      // Transmit.
    input wire logic                        strength_tick,  // Update tick.
    input wire logic [7:0]                  strength_in,    // Raw strength.
    input wire logic                        ant_one_sel,    // Line one.
    input wire logic                        ant_two_sel,    // Line two.
    input wire logic                        cca_status,     // Above threshold.
    input wire logic [2:0]                  pin_out         // Pins.
);
    import adrc_pkg::*;
    logic [7:0] ctrl_r;
    logic [7:0] cfg0_r;
    logic [7:0] cfg1_r;
    logic [7:0] cfg2_r;
    logic [7:0] thr_r;
    logic [7:0] str_r;
    logic       str_v_r;
    logic       m0;
    logic       idle_lvl;
    assign m0       = ctrl_r[5];
    assign idle_lvl = ctrl_r[7] ? ctrl_r[5] : ctrl_r[6];
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ctrl_r <= RST_OPER_CTRL_TWO;
            cfg0_r <= RST_PIN_CFG;
            cfg1_r <= RST_PIN_CFG;
            cfg2_r <= RST_PIN_CFG;
            thr_r  <= RST_CC_THRESHOLD;
        end else if (reg_wr) begin
            case (reg_addr)
                OFS_OPER_CTRL_TWO: ctrl_r <= reg_wdata;
                OFS_PIN_CFG_ZERO:  cfg0_r <= reg_wdata;
                OFS_PIN_CFG_ONE:   cfg1_r <= reg_wdata;
                OFS_PIN_CFG_TWO:   cfg2_r <= reg_wdata;
                OFS_CC_THRESHOLD:  thr_r  <= reg_wdata;
                default: ;
            endcase
        end
    end
    always_ff @(posedge core_clk) begin
        if (rst) begin
            str_v_r <= 1'b0;
        end else if (strength_tick) begin
            str_v_r <= 1'b1;
            str_r   <= strength_in;
        end
    end
    ////////////////////////////////////////////////////////////////
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence s_rd(logic [7:0] a);
        reg_rd && reg_addr == a;
    endsequence
    property p_rd_ctrl;
        s_rd(OFS_OPER_CTRL_TWO) |=> reg_rdata == $past(ctrl_r);
    endproperty
    a_rd_ctrl: assert property (p_rd_ctrl) else $error("control readback wrong");
    property p_rd_thr;
        s_rd(OFS_CC_THRESHOLD) |=> reg_rdata == $past(thr_r);
    endproperty
    a_rd_thr: assert property (p_rd_thr) else $error("threshold readback wrong");
    // A read that meets an update tick or comes before the first tick is left unchecked; other reads return the held value.
    property p_rd_str;
        s_rd(OFS_STRENGTH) ##0 (str_v_r && !strength_tick) |=> reg_rdata == $past(str_r);
    endproperty
    a_rd_str: assert property (p_rd_str) else $error("strength readback wrong");
    property p_rd_idle;
        !reg_rd |=> reg_rdata == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
    property p_fixed;
        !ctrl_r[7] && (rx_active || tx_active) |=> ant_one_sel == $past(m0) && ant_two_sel != $past(m0);
    endproperty
    a_fixed: assert property (p_fixed) else $error("fixed mode lines wrong");
    property p_idle;
        !rx_active && !tx_active |=> ant_one_sel == $past(idle_lvl) && ant_two_sel == $past(idle_lvl);
    endproperty
    a_idle: assert property (p_idle) else $error("idle lines wrong");
    property p_pin_one;
        cfg0_r[4:0] == FUNC_ANT_ONE |=> pin_out[0] == ant_one_sel;
    endproperty
    a_pin_one: assert property (p_pin_one) else $error("pin zero not line one");
    property p_pin_cc;
        cfg2_r[4:0] == FUNC_CLEAR_CHANNEL ##1 $stable(cca_status) |-> pin_out[2] == cca_status;
    endproperty
    a_pin_cc: assert property (p_pin_cc) else $error("pin two not threshold flag");
    property p_pin_dflt;
        cfg0_r[4:0] == FUNC_DEFAULT && cfg1_r[4:0] == FUNC_DEFAULT |=> pin_out[1:0] == 2'b10;
    endproperty
    a_pin_dflt: assert property (p_pin_dflt) else $error("pin defaults wrong");
endmodule

bind adrc_top adrc_monitor u_monitor (.*);

// >>> sim/adrc_rf_switch.sv
/*
 * Model of the external two-way RF switch and its two antennas.
 * Assumes the bench sets the strength seen on each antenna.
 */
module adrc_rf_switch (
    input  wire logic       core_clk,      // Clock.
    input  wire logic       ant_one_sel,   // Line one.
    input  wire logic       ant_two_sel,   // Line two.
    input  wire logic [7:0] level_one,     // Antenna one strength.
    input  wire logic [7:0] level_two,     // Antenna two strength.
    output logic      [7:0] strength_out   // Strength at the receiver.
);
    logic [7:0] last_r = 8'h00;
    // With no single antenna routed the receiver sees a value that flips every cycle.
    assign strength_out = (ant_one_sel ^ ant_two_sel) ?
                          (ant_one_sel ? level_one : level_two) : ~last_r;
    always_ff @(posedge core_clk) begin
        last_r <= strength_out;
    end
endmodule

// >>> sim/adrc_top_tb.sv
/*
 * Self-checking bench for adrc_top with the RF switch model.
 * Assumes the checker is bound to the design by its own file.
 */
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin errors++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module adrc_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import adrc_pkg::*;
    logic       core_clk = 1'b0;
    logic       rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    logic       rx_active = 1'b0;
    logic       tx_active = 1'b0;
    logic       strength_tick = 1'b0;
    logic       preamble_seen = 1'b0;
    logic       packet_end = 1'b0;
    logic [7:0] level_one = 8'h00;
    logic [7:0] level_two = 8'h00;
    logic [7:0] reg_rdata, strength_in, rv;
    logic       ant_one_sel, ant_two_sel, cca_status;
    logic [2:0] pin_out;
    int         errors = 0;
    int         checked = 0;
    int         cycles = 0;
    adrc_top u_dut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .rx_active(rx_active), .tx_active(tx_active), .strength_tick(strength_tick),
        .strength_in(strength_in), .preamble_seen(preamble_seen), .packet_end(packet_end),
        .ant_one_sel(ant_one_sel), .ant_two_sel(ant_two_sel), .cca_status(cca_status),
        .pin_out(pin_out));
    adrc_rf_switch u_switch (.core_clk(core_clk), .ant_one_sel(ant_one_sel),
        .ant_two_sel(ant_two_sel), .level_one(level_one), .level_two(level_two),
        .strength_out(strength_in));
    always #12.5 core_clk = ~core_clk;
    ////////////////////////////////////////////////////////////////
    task automatic wrap_up;
        if (errors == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            errors++;
            wrap_up();
        end
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge core_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        rv = reg_rdata;
    endtask
    // Kind 0 is a strength tick, 1 a preamble detection, 2 a packet end.
    task automatic pulse(input int k);
        @(posedge core_clk);
        strength_tick <= (k == 0);
        preamble_seen <= (k == 1);
        packet_end    <= (k == 2);
        @(posedge core_clk);
        {strength_tick, preamble_seen, packet_end} <= 3'b000;
        cyc(6);
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_reset;
        `CHK({ant_one_sel, ant_two_sel, cca_status}, 3'b000)
        `CHK(pin_out, 3'b010)
        rd(OFS_OPER_CTRL_TWO);
        `CHK(rv, RST_OPER_CTRL_TWO)
        rd(OFS_CC_THRESHOLD);
        `CHK(rv, RST_CC_THRESHOLD)
        rd(8'h55);
        `CHK(rv, 8'h00)
    endtask
    task automatic t_fixed;
        logic [2:0] m;
        logic       il;
        wr(OFS_PIN_CFG_ZERO, {3'b000, FUNC_ANT_ONE});
        wr(OFS_PIN_CFG_ONE, {3'b000, FUNC_ANT_TWO});
        wr(OFS_PIN_CFG_TWO, {3'b000, FUNC_CLEAR_CHANNEL});
        level_one <= 8'h21;
        for (int i = 0; i < 8; i++) begin
            m  = i[2:0];
            il = m[2] ? m[0] : m[1];
            wr(OFS_OPER_CTRL_TWO, {m, 5'h15});
            rd(OFS_OPER_CTRL_TWO);
            `CHK(rv, {m, 5'h15})
            `CHK({ant_one_sel, ant_two_sel}, {il, il})
            `CHK(pin_out[1:0], {il, il})
            if (!m[2]) begin
                @(posedge core_clk) rx_active <= 1'b1;
                cyc(2);
                `CHK({ant_one_sel, ant_two_sel}, {m[0], !m[0]})
                `CHK(pin_out[1:0], {!m[0], m[0]})
                // Antenna one sees a level above the zero threshold, antenna two none.
                pulse(0);
                pulse(1);
                `CHK(cca_status, m[0])
                `CHK(pin_out[2], m[0])
                @(posedge core_clk) {rx_active, tx_active} <= 2'b01;
                cyc(2);
                `CHK({ant_one_sel, ant_two_sel}, {m[0], !m[0]})
                @(posedge core_clk) tx_active <= 1'b0;
            end
        end
    endtask
    task automatic t_div(input logic [2:0] m, input logic [7:0] l1, input logic [7:0] l2,
                         input logic [7:0] th, input logic two, input logic cc);
        int dw;
        dw = m[1] ? DWELL_BEACON_TICKS : DWELL_ASYNC_TICKS;
        wr(OFS_OPER_CTRL_TWO, {m, 5'h00});
        wr(OFS_CC_THRESHOLD, th);
        level_one <= l1;
        level_two <= l2;
        @(posedge core_clk) rx_active <= 1'b1;
        cyc(3);
        if (!m[1]) pulse(1);
        `CHK({ant_one_sel, ant_two_sel}, 2'b10)
        // The sender's preamble outlasts both dwells.
        repeat (dw) pulse(0);
        `CHK({ant_one_sel, ant_two_sel}, 2'b01)
        repeat (dw) pulse(0);
        `CHK({ant_one_sel, ant_two_sel}, {!two, two})
        `CHK(cca_status, cc)
        `CHK(pin_out[2], cc)
        rd(OFS_STRENGTH);
        `CHK(rv, l2)
        `CHK(cca_status, cc)
        wr(OFS_STRENGTH, ~l2);
        rd(OFS_STRENGTH);
        `CHK(rv, l2)
        @(posedge core_clk);
        level_one <= l2;
        level_two <= l1;
        pulse(0);
        pulse(0);
        `CHK({ant_one_sel, ant_two_sel}, {!two, two})
        pulse(2);
        @(posedge core_clk) rx_active <= 1'b0;
        cyc(2);
        `CHK({ant_one_sel, ant_two_sel}, {m[0], m[0]})
        @(posedge core_clk) tx_active <= 1'b1;
        cyc(2);
        `CHK({ant_one_sel, ant_two_sel}, {!two, two})
        @(posedge core_clk) tx_active <= 1'b0;
        cyc(2);
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        cyc(1);
        t_reset();
        t_fixed();
        t_div(3'b110, 8'h30, 8'h50, 8'h40, 1'b1, 1'b1);
        t_div(3'b101, 8'h60, 8'h20, 8'h70, 1'b0, 1'b0);
        t_div(3'b111, 8'h44, 8'h44, 8'h43, 1'b0, 1'b1);
        t_div(3'b100, 8'h10, 8'h90, 8'h90, 1'b1, 1'b0);
        wrap_up();
    end
endmodule
